// ---- src/via_map.svh ----
`ifndef VIA_MAP_SVH
`define VIA_MAP_SVH

// Register offsets
`define VIA_NMI_CTRL_OFS 5'h00
`define VIA_IEN_LOW_OFS 5'h01
`define VIA_IEN_HIGH_OFS 5'h02
`define VIA_PRIO_OFS 5'h04
`define VIA_FLAG_OFS 5'h08
`define VIA_MASK_OFS 5'h10
`define VIA_ACTIVE_OFS 5'h18
`define VIA_GRANT_OFS 5'h19

// Field positions and widths
`define VIA_GLOBAL_EN_BIT 7
`define VIA_NMI_SRC_CNT 6

// Reset values
`define VIA_NMI_CTRL_RST 6'h00
`define VIA_IEN_RST 14'h0000
`define VIA_GLOBAL_EN_RST 1'b0
`define VIA_PRIO_RST 28'h0000000
`define VIA_FLAG_RST 40'h0000000000
`define VIA_MASK_RST 40'hffffffffff

// Vectors
`define VIA_VEC_BASE 16'h0003
`define VIA_VEC_STEP 16'h0008
`define VIA_VEC_NMI 16'h0073

// Levels
`define VIA_NMI_LEVEL 3'h4

`endif

// ---- src/via_pkg.sv ----
package via_pkg;
    typedef logic [2:0] via_level_t;
    typedef logic [3:0] via_pos_t;
    typedef logic [15:0] via_vec_t;
    typedef logic [39:0] via_src_t;
endpackage

// ---- src/via_top.sv ----
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
`include "via_map.svh"
module via_top
    import via_pkg::*;
#(
    parameter int NODES = 14,
    parameter int SOURCES = 40
) (
    input wire logic core_clk, // System clock, 40 MHz
    input wire logic rst, // Synchronous reset, active high
    input wire logic [4:0] reg_addr, // Register address
    input wire logic [7:0] reg_wdata, // Register write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [7:0] reg_rdata, // Read data, cycle after strobe
    input wire logic [39:0] src_event, // One-cycle source event pulses
    output logic int_req, // Level request to the core
    output logic [15:0] int_vec, // Vector of the pending grant
    input wire logic int_ack, // Core takes the vector
    input wire logic int_reti // Core returns from service
);

    generate
        if (NODES != 14 || SOURCES != 40) begin : g_check
            $error("via_top supports exactly 14 nodes and 40 sources");
        end
        if (`VIA_NMI_SRC_CNT != 6) begin : g_nmi_check
            $error("via_top expects six non-maskable sources");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Source layout: 0-5 non-maskable, then node groups in polling order

    // Polling position of a source: 0 is the non-maskable node, k+1 is node k
    function automatic via_pos_t src_pos(input int i);
        via_pos_t p;
        p = 4'h0;
        if (i < 6) begin
            p = 4'h0;
        end else if (i < 11) begin
            p = 4'(i - 5);
        end else if (i < 15) begin
            p = 4'h6;
        end else if (i < 19) begin
            p = 4'h7;
        end else if (i < 20) begin
            p = 4'h8;
        end else if (i < 27) begin
            p = 4'h9;
        end else if (i < 32) begin
            p = 4'ha;
        end else begin
            p = 4'(11 + (i - 32) / 2);
        end
        return p;
    endfunction

    // Set of sources that feed one polling position
    function automatic via_src_t pos_sources(input int p);
        via_src_t m;
        m = '0;
        for (int i = 0; i < SOURCES; i++) begin
            if (src_pos(i) == 4'(p)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction

    // Address inside a run of consecutive byte registers
    function automatic logic in_window(input logic [4:0] addr, input logic [4:0] base, input logic [2:0] count);
        logic hit;
        hit = addr >= base && addr < base + 5'(count);
        return hit;
    endfunction

    // Fixed vector of a polling position
    function automatic via_vec_t pos_vector(input via_pos_t p);
        via_vec_t v;
        v = `VIA_VEC_NMI;
        if (p != 4'h0) begin
            v = `VIA_VEC_BASE + `VIA_VEC_STEP * via_vec_t'(p - 4'h1);
        end
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Registers

    logic [5:0] nmi_control_register_q;
    logic [13:0] node_enable_q;
    logic global_enable_q;
    logic [27:0] prio_q;
    via_src_t flag_q;
    via_src_t flag_d;
    via_src_t mask_q;
    logic [4:0] active_q;
    logic [4:0] active_d;
    logic [7:0] rdata_q;
    logic req_q;
    via_vec_t vec_q;
    via_level_t grant_lvl_q;
    via_pos_t grant_pos_q;

    // Address decode, shared by the write strobes and the read mux
    wire sel_nmi = reg_addr == `VIA_NMI_CTRL_OFS;
    wire sel_ien_low = reg_addr == `VIA_IEN_LOW_OFS;
    wire sel_ien_high = reg_addr == `VIA_IEN_HIGH_OFS;
    wire sel_prio = in_window(reg_addr, `VIA_PRIO_OFS, 3'h4);
    wire sel_flag = in_window(reg_addr, `VIA_FLAG_OFS, 3'h5);
    wire sel_mask = in_window(reg_addr, `VIA_MASK_OFS, 3'h5);
    wire sel_active = reg_addr == `VIA_ACTIVE_OFS;
    wire sel_grant = reg_addr == `VIA_GRANT_OFS;
    wire [1:0] byte_sel = reg_addr[1:0];
    wire wr_nmi = reg_wr && sel_nmi;
    wire wr_ien_low = reg_wr && sel_ien_low;
    wire wr_ien_high = reg_wr && sel_ien_high;
    wire wr_prio = reg_wr && sel_prio;
    wire wr_flag = reg_wr && sel_flag;
    wire wr_mask = reg_wr && sel_mask;

    // Byte-wide write data spread to the 40-bit source layout
    wire [5:0] src_byte_shift = {reg_addr[2:0], 3'h0};
    wire via_src_t wide_wdata = via_src_t'(reg_wdata) << src_byte_shift;
    wire via_src_t wide_lane = via_src_t'(8'hff) << src_byte_shift;
    wire via_src_t flag_clr = wr_flag ? wide_wdata : '0;

    // Set wins over a clear in the same cycle
    assign flag_d = (flag_q & ~flag_clr) | src_event;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            flag_q <= `VIA_FLAG_RST;
        end else begin
            flag_q <= flag_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mask_q <= `VIA_MASK_RST;
        end else if (wr_mask) begin
            mask_q <= (mask_q & ~wide_lane) | wide_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            nmi_control_register_q <= `VIA_NMI_CTRL_RST;
        end else if (wr_nmi) begin
            nmi_control_register_q <= reg_wdata[5:0];
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            node_enable_q <= `VIA_IEN_RST;
            global_enable_q <= `VIA_GLOBAL_EN_RST;
        end else if (wr_ien_low) begin
            node_enable_q[5:0] <= reg_wdata[5:0];
            global_enable_q <= reg_wdata[`VIA_GLOBAL_EN_BIT];
        end else if (wr_ien_high) begin
            node_enable_q[13:6] <= reg_wdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            prio_q <= `VIA_PRIO_RST;
        end else if (wr_prio && byte_sel != 2'h3) begin
            prio_q[{byte_sel, 3'h0} +: 8] <= reg_wdata;
        end else if (wr_prio) begin
            prio_q[27:24] <= reg_wdata[3:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Node requests

    via_src_t live;
    logic [14:0] pos_req;
    via_level_t pos_lvl [15];

    // Non-maskable sources pass only with their own control bit
    assign live = flag_q & mask_q & {{(SOURCES - `VIA_NMI_SRC_CNT){1'b1}}, nmi_control_register_q};

    // Non-maskable level sits above every programmable level, so it always wins
    assign pos_req[0] = |(live & pos_sources(0));
    assign pos_lvl[0] = `VIA_NMI_LEVEL;

    genvar gk;
    generate
        for (gk = 0; gk < NODES; gk++) begin : g_node
            // Shared enable gates the whole node, the flags stay visible
            assign pos_req[gk + 1] = |(live & pos_sources(gk + 1)) && node_enable_q[gk] && global_enable_q;
            assign pos_lvl[gk + 1] = {1'b0, prio_q[2 * gk +: 2]};
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Arbitration

    via_level_t win_lvl;
    via_pos_t win_pos;
    logic win_any;

    // Walking downward with >= lets the lowest position win a tie
    always_comb begin
        win_lvl = 3'h0;
        win_pos = 4'h0;
        win_any = 1'b0;
        for (int p = 14; p >= 0; p--) begin
            if (pos_req[p] && (!win_any || pos_lvl[p] >= win_lvl)) begin
                win_lvl = pos_lvl[p];
                win_pos = 4'(p);
                win_any = 1'b1;
            end
        end
    end

    // Nothing in service at or above the winner's level
    wire preempt = win_any && (active_q >> win_lvl) == 5'h00;

    wire via_vec_t win_vec = pos_vector(win_pos);

    // An ack is honoured only while a request stands
    wire ack_take = int_ack && req_q;

    // The grant freezes in the cycle of the ack so the core sees one vector
    always_ff @(posedge core_clk) begin
        if (rst) begin
            req_q <= 1'b0;
            vec_q <= 16'h0000;
            grant_lvl_q <= 3'h0;
            grant_pos_q <= 4'h0;
        end else if (ack_take) begin
            req_q <= 1'b0;
        end else begin
            req_q <= preempt;
            vec_q <= win_vec;
            grant_lvl_q <= win_lvl;
            grant_pos_q <= win_pos;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // In-service levels, one bit per level

    logic [4:0] top_bit;

    // Isolate the highest set bit; that is the level being left on return
    always_comb begin
        top_bit = 5'h00;
        for (int l = 0; l < 5; l++) begin
            if (active_q[l]) begin
                top_bit = 5'h01 << l;
            end
        end
    end

    always_comb begin
        active_d = active_q;
        if (int_reti) begin
            active_d = active_d & ~top_bit;
        end
        // A return and a take in one cycle: the return is applied first
        if (ack_take) begin
            active_d = active_d | (5'h01 << grant_lvl_q);
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            active_q <= 5'h00;
        end else begin
            active_q <= active_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read path

    wire [7:0] flag_byte = 8'(flag_q >> src_byte_shift);
    wire [7:0] mask_byte = 8'(mask_q >> src_byte_shift);
    wire [7:0] prio_byte = 8'({4'h0, prio_q} >> {byte_sel, 3'h0});
    wire [7:0] nmi_byte = {2'h0, nmi_control_register_q};
    wire [7:0] ien_low_byte = {global_enable_q, 1'b0, node_enable_q[5:0]};
    wire [7:0] active_byte = {3'h0, active_q};
    wire [7:0] grant_byte = {req_q, grant_lvl_q, grant_pos_q};
    logic [7:0] rd_mux;

    // Unmapped addresses read as zero so software can probe the map safely

    always_comb begin
        rd_mux = 8'h00;
        if (sel_nmi) begin
            rd_mux = nmi_byte;
        end else if (sel_ien_low) begin
            rd_mux = ien_low_byte;
        end else if (sel_ien_high) begin
            rd_mux = node_enable_q[13:6];
        end else if (sel_prio) begin
            rd_mux = prio_byte;
        end else if (sel_flag) begin
            rd_mux = flag_byte;
        end else if (sel_mask) begin
            rd_mux = mask_byte;
        end else if (sel_active) begin
            rd_mux = active_byte;
        end else if (sel_grant) begin
            rd_mux = grant_byte;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rd_mux;
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;
    assign int_req = req_q;
    assign int_vec = vec_q;

endmodule // via_top

// ---- dv/via_assertions.sv ----
`timescale 1ns/100ps
module via_assertions #(
    parameter int NODES = 14,
    parameter int SOURCES = 40
) (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic [4:0] reg_addr, // Address
    input wire logic [7:0] reg_wdata, // Wdata
    input wire logic reg_wr, // Write
    input wire logic reg_rd, // Read
    input wire logic [7:0] reg_rdata, // Rdata
    input wire logic [39:0] src_event, // Events
    input wire logic int_req, // Request
    input wire logic [15:0] int_vec, // Vector
    input wire logic int_ack, // Ack
    input wire logic int_reti // Return
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);
    wire logic cause = (src_event != 40'h0) || reg_wr || int_reti;
    sequence nmi_taken;
        int_req && int_ack && int_vec == 16'h0073;
    endsequence
    sequence no_return;
        !int_reti [*4];
    endsequence
    chk_ack_drop: assert property (int_req && int_ack |=> !int_req)
        else $error("request kept after ack");
    chk_nmi_hold: assert property (nmi_taken ##1 no_return |-> !int_req)
        else $error("nmi service preempted");
    chk_vec_legal: assert property (int_req |-> int_vec == 16'h0073 ||
        (int_vec[2:0] == 3'h3 && int_vec <= 16'h006b)) else $error("vector off table");
    chk_reset_quiet: assert property (disable iff (1'b0) rst |=> !int_req && int_vec == 16'h0 && reg_rdata == 8'h0)
        else $error("outputs active in reset");
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data without read");
    chk_flag_seen: assert property (reg_rd && reg_addr == 5'h08 |=>
        (reg_rdata & $past(src_event[7:0], 2)) == $past(src_event[7:0], 2)) else $error("flag not sticky");
    chk_req_cause: assert property ($rose(int_req) |-> $past(cause) || $past(cause, 2))
        else $error("request without cause");
    chk_req_hold: assert property (int_req && !int_ack && !$past(reg_wr) |=> int_req)
        else $error("pending request lost");
endmodule // via_assertions
bind via_top via_assertions #(.NODES(NODES), .SOURCES(SOURCES)) chk (.*);

// ---- dv/via_core_model.sv ----
`timescale 1ns/100ps
module via_core_model (
    input wire logic core_clk, // Clock
    input wire logic rst, // Reset
    input wire logic int_req, // Request
    input wire logic [3:0] ack_dly, // Take delay
    output logic int_ack = 1'b0, // Taken
    output logic int_reti = 1'b0 // Return
);
    int wt = 0;
    int svc = 0;
    int depth = 0;
    // One timer reloaded on every entry, so nested routines return innermost first
    always @(posedge core_clk) begin
        int_ack <= 1'b0;
        int_reti <= 1'b0;
        if (rst) begin
            depth = 0;
        end else if (int_req && !int_ack && wt >= ack_dly) begin
            int_ack <= 1'b1;
            depth++;
            svc = 40;
            wt = 0;
        end else begin
            wt = int_req ? wt + 1 : 0;
            svc--;
            if (depth > 0 && svc <= 0) begin
                int_reti <= 1'b1;
                depth--;
                svc = 40;
            end
        end
    end
endmodule // via_core_model

// ---- dv/via_top_tb.sv ----
`timescale 1ns/100ps
`include "via_map.svh"
module via_top_tb;
    import via_pkg::*;
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin fail_count++; $display("[ERR] %s exp %h got %h", n, e, g); end end
    logic core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    via_src_t src_event = '0;
    logic int_req, int_ack, int_reti;
    via_vec_t int_vec;
    logic [3:0] ack_dly = 4'h0;
    int fail_count = 0, n_checks = 0, n_reti = 0;
    int seed = 32'h9599948a;
    int first[16] = '{0, 6, 7, 8, 9, 10, 11, 15, 19, 20, 27, 32, 34, 36, 38, 40};
    via_vec_t got[$], exq[$];
    logic [13:0] en_m;
    logic [5:0] nmi_m;
    logic [31:0] prio_m;
    via_src_t mask_m, flag_m = '0;
    via_top uut (.*);
    via_core_model core (.*);
    initial forever #12.5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        if (int_ack && int_req) got.push_back(int_vec);
        if (int_reti) n_reti++;
    end
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic chkreg(input logic [4:0] a, input logic [7:0] e);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 `CHK("reg", e, reg_rdata)
        @(posedge core_clk);
    endtask
    task automatic cfg();
        wr(`VIA_NMI_CTRL_OFS, {2'b00, nmi_m});
        wr(`VIA_IEN_LOW_OFS, {2'b10, en_m[5:0]});
        wr(`VIA_IEN_HIGH_OFS, en_m[13:6]);
        for (int i = 0; i < 5; i++) begin
            if (i < 4) wr(5'(`VIA_PRIO_OFS + i), prio_m[8*i+:8]);
            wr(5'(`VIA_MASK_OFS + i), mask_m[8*i+:8]);
        end
    endtask
    task automatic pulse(input via_src_t ev);
        src_event <= ev;
        flag_m |= ev;
        @(posedge core_clk);
        src_event <= '0;
    endtask
    // Acts as the service routine: each node's flags are cleared long before its return
    task automatic serve();
        via_src_t clr;
        int p;
        foreach (exq[i]) begin
            repeat (300) if (got.size() <= i) @(posedge core_clk);
            `CHK("vector", exq[i], got[i])
            p = exq[i] == `VIA_VEC_NMI ? 0 : (exq[i] - 3) / 8 + 1;
            clr = '0;
            for (int s = first[p]; s < first[p+1]; s++) clr[s] = 1'b1;
            flag_m &= ~clr;
            for (int b = 0; b < 5; b++) wr(5'(`VIA_FLAG_OFS + b), clr[8*b+:8]);
        end
    endtask
    task automatic run(input via_src_t ev);
        int key[$];
        logic on;
        got = {};
        pulse(ev);
        for (int b = 0; b < 5; b++) chkreg(5'(`VIA_FLAG_OFS + b), flag_m[8*b+:8]);
        for (int p = 0; p < 15; p++) begin
            on = 1'b0;
            for (int s = first[p]; s < first[p+1]; s++) on |= flag_m[s] & mask_m[s] & (p == 0 ? nmi_m[s] : en_m[p-1]);
            if (on) key.push_back((p == 0 ? `VIA_NMI_LEVEL : prio_m[2*p-2+:2]) * 16 + 15 - p);
        end
        key.rsort();
        exq = {};
        foreach (key[k]) exq.push_back(key[k] % 16 == 15 ? `VIA_VEC_NMI : 16'(3 + 8 * (14 - key[k] % 16)));
        serve();
        repeat (100) @(posedge core_clk);
        `CHK("idle", 1'b0, int_req)
        `CHK("grants", exq.size(), got.size())
        for (int b = 0; b < 5; b++) wr(5'(`VIA_FLAG_OFS + b), 8'hff);
        flag_m = '0;
    endtask
    task automatic end_sim();
        if (fail_count == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    initial begin
        #(25 * 80000);
        fail_count++;
        end_sim();
    end
    initial begin
        logic [4:0] ra[7] = '{5'h00, 5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1f};
        logic [7:0] rv[7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'h00};
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        foreach (ra[i]) chkreg(ra[i], rv[i]);
        en_m = '1;
        nmi_m = '1;
        mask_m = '1;
        prio_m = 32'h20;
        cfg();
        got = {};
        exq = '{16'h0003};
        pulse(40'h40);
        serve();
        got = {};
        exq = '{16'h0013, 16'h000b};
        pulse(40'h180);
        serve();
        `CHK("nested returns", 2, n_reti)
        chkreg(`VIA_ACTIVE_OFS, 8'h01);
        repeat (60) @(posedge core_clk);
        chkreg(`VIA_ACTIVE_OFS, 8'h00);
        chkreg(`VIA_GRANT_OFS, 8'h00);
        for (int it = 0; it < 30; it++) begin
            en_m = 14'($random(seed));
            nmi_m = 6'($random(seed));
            prio_m = $random(seed);
            mask_m = 40'({$random(seed), $random(seed)} | {$random(seed), $random(seed)});
            ack_dly <= 4'($random(seed)) & 4'h3;
            cfg();
            chkreg(`VIA_IEN_HIGH_OFS, en_m[13:6]);
            run(40'({$random(seed), $random(seed)} & {$random(seed), $random(seed)}));
        end
        end_sim();
    end
endmodule // via_top_tb
